/* File: pmx_pkg.sv */
// Shared constants for the port A and port B alternate-function override logic.
package pmx_pkg;

    // Pin counts and the position of each port inside the combined pin vector.
    localparam int PA_W     = 4;
    localparam int PB_W     = 8;
    localparam int NPIN     = PA_W + PB_W;
    localparam int PA_BASE  = 0;
    localparam int PB_BASE  = PA_W;

    // Port B bit positions of the alternate functions.
    localparam int PB_XTAL2 = 7;
    localparam int PB_CLKIN = 6;
    localparam int PB_SCK   = 5;
    localparam int PB_MISO  = 4;
    localparam int PB_MOSI  = 3;
    localparam int PB_SSEL  = 2;
    localparam int PB_CMPA  = 1;
    localparam int PB_CAPT  = 0;

    // Port A bit positions that carry converter inputs.
    localparam int PA_ANA7  = 1;
    localparam int PA_ANA6  = 0;

    // Converter channel numbers and first pin-change source numbers of ports A and B.
    localparam int ANALOG_CH_PA1   = 7;
    localparam int ANALOG_CH_PA0   = 6;
    localparam int PINCHG_A_FIRST  = 24;
    localparam int PINCHG_B_FIRST  = 0;

    // Clock source selection codes.
    localparam logic [1:0] CLKSRC_EXTERNAL    = 2'h0;
    localparam logic [1:0] CLKSRC_RESERVED    = 2'h1;
    localparam logic [1:0] CLKSRC_INTERNAL    = 2'h2;
    localparam logic [1:0] CLKSRC_INTERNAL_LF = 2'h3;

    // Reset values of the synchronised input and read-back registers.
    localparam logic [PA_W-1:0] PA_RST = 4'h0;
    localparam logic [PB_W-1:0] PB_RST = 8'h00;

endpackage : pmx_pkg

/* File: pmx_pin_ctrl.sv */
// Generic override logic of one port pin.
`timescale 1ns/10ps
module pmx_pin_ctrl (
    // Port register bits and global controls
    input  wire logic dir_bit,
    input  wire logic out_bit,
    input  wire logic global_pullup_disable,
    input  wire logic cpu_sleep,
    // Overrides from the alternate-function owner
    input  wire logic pullup_override_en,
    input  wire logic pullup_override_val,
    input  wire logic dir_override_en,
    input  wire logic dir_override_val,
    input  wire logic value_override_en,
    input  wire logic value_override_val,
    input  wire logic din_enable_override_en,
    input  wire logic din_enable_override_val,
    // Pad side
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe_n,
    output logic      pullup_en,
    // Digital input towards the alternate functions
    output logic      pin_digital_in
);

    logic drive_en;
    logic din_en;

    always_comb begin
        if (pullup_override_en) begin
            pullup_en = pullup_override_val;
        end else begin
            pullup_en = ~dir_bit & out_bit & ~global_pullup_disable;
        end
    end

    assign drive_en = dir_override_en ? dir_override_val : dir_bit;
    assign pad_oe_n = ~drive_en;

    // The value is only seen on the pad while the driver is enabled.
    assign pad_out = value_override_en ? value_override_val : out_bit;

    // A disabled input buffer is clamped low so a floating pad draws no current.
    assign din_en = din_enable_override_en ? din_enable_override_val : ~cpu_sleep;
    assign pin_digital_in = pad_in & din_en;

endmodule : pmx_pin_ctrl

/* File: pmx_port_mux.sv */
// Alternate-function override multiplexer for port A bits 3:0 and port B bits 7:0.
`timescale 1ns/10ps
module pmx_port_mux
    import pmx_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    // Port registers and global controls
    input  wire logic [PA_W-1:0] porta_dir,
    input  wire logic [PA_W-1:0] porta_out,
    input  wire logic [PB_W-1:0] portb_dir,
    input  wire logic [PB_W-1:0] portb_out,
    input  wire logic            global_pullup_disable,
    input  wire logic            cpu_sleep,
    // Pin-change masks and group enables
    input  wire logic [PA_W-1:0] pinchg_mask_a,
    input  wire logic            pinchg_group_a_en,
    input  wire logic [PB_W-1:0] pinchg_mask_b,
    input  wire logic            pinchg_group_b_en,
    // Converter pin controls; each forces that pin's digital input on
    input  wire logic            analog7_din_disable,
    input  wire logic            analog6_din_disable,
    // Serial peripheral
    input  wire logic            serial_periph_en,
    input  wire logic            serial_master_sel,
    input  wire logic            spi_sck_out,
    input  wire logic            spi_master_out,
    input  wire logic            spi_slave_out,
    // Timer 1 compare outputs
    input  wire logic            timer1_cmp_a_en,
    input  wire logic            timer1_cmp_a_out,
    input  wire logic            timer1_cmp_b_en,
    input  wire logic            timer1_cmp_b_out,
    // Clock configuration
    input  wire logic [1:0]      clock_source_select,
    input  wire logic            pb7_clock_use,
    input  wire logic            clock_out_option,
    input  wire logic            divided_clock_out,
    // Port A pads
    input  wire logic [PA_W-1:0] porta_pad_in,
    output logic      [PA_W-1:0] porta_pad_out,
    output logic      [PA_W-1:0] porta_pad_oe_n,
    output logic      [PA_W-1:0] porta_pullup_en,
    // Port B pads
    input  wire logic [PB_W-1:0] portb_pad_in,
    output logic      [PB_W-1:0] portb_pad_out,
    output logic      [PB_W-1:0] portb_pad_oe_n,
    output logic      [PB_W-1:0] portb_pullup_en,
    // Pin-change sources
    output logic      [PA_W-1:0] pinchg_src_a,
    output logic      [PB_W-1:0] pinchg_src_b,
    // Analog paths
    output logic                 analog_ch7_in,
    output logic                 analog_ch6_in,
    // Serial peripheral inputs
    output logic                 spi_sck_in,
    output logic                 spi_master_in,
    output logic                 spi_slave_in,
    output logic                 spi_slave_select_n,
    output logic                 spi_slave_active,
    // Timer and clock inputs
    output logic                 timer1_capture_in,
    output logic                 ext_clock_in,
    output logic                 internal_osc_selected,
    // Register read-back
    output logic      [PA_W-1:0] porta_in_rd,
    output logic      [PB_W-1:0] portb_dir_rd,
    output logic      [PB_W-1:0] portb_out_rd,
    output logic      [PB_W-1:0] portb_in_rd
);

    function automatic logic is_internal_osc(input logic [1:0] sel);
        is_internal_osc = (sel == CLKSRC_INTERNAL) || (sel == CLKSRC_INTERNAL_LF);
    endfunction : is_internal_osc

    function automatic logic is_external_clock(input logic [1:0] sel);
        is_external_clock = (sel == CLKSRC_EXTERNAL);
    endfunction : is_external_clock

    logic [NPIN-1:0] pullup_override_en;
    logic [NPIN-1:0] pullup_override_val;
    logic [NPIN-1:0] dir_override_en;
    logic [NPIN-1:0] dir_override_val;
    logic [NPIN-1:0] value_override_en;
    logic [NPIN-1:0] value_override_val;
    logic [NPIN-1:0] din_enable_override_en;
    logic [NPIN-1:0] din_enable_override_val;
    logic [NPIN-1:0] pin_dir;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pad_in;
    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe_n;
    logic [NPIN-1:0] pullup_en;
    logic [NPIN-1:0] pin_digital_in;
    logic [NPIN-1:0] sync_meta;
    logic [NPIN-1:0] sync_pin;
    logic            spi_slave_mode;
    logic            spi_master_mode;
    logic            pb6_clock_pin;
    logic            pb7_clock_pin;
    logic [PB_W-1:0] pb_mask;
    logic [PB_W-1:0] pb_pinchg_on;
    logic [PA_W-1:0] pa_pinchg_on;

    assign spi_slave_mode        = serial_periph_en & ~serial_master_sel;
    assign spi_master_mode       = serial_periph_en & serial_master_sel;
    assign internal_osc_selected = is_internal_osc(clock_source_select);
    assign pb6_clock_pin         = is_external_clock(clock_source_select);
    assign pb7_clock_pin         = pb7_clock_use;
    assign pa_pinchg_on          = pinchg_mask_a & {PA_W{pinchg_group_a_en}};
    assign pb_pinchg_on          = pinchg_mask_b & {PB_W{pinchg_group_b_en}};

    assign pin_dir = {portb_dir, porta_dir};
    assign pin_out = {portb_out, porta_out};
    assign pad_in  = {portb_pad_in, porta_pad_in};

    // Overrides are pure decode of peripheral state, so a mode change reaches the pad
    // in the same cycle and the clock-out path keeps working while nrst is low.
    always_comb begin
        pullup_override_en      = '0;
        pullup_override_val     = '0;
        dir_override_en         = '0;
        dir_override_val        = '0;
        value_override_en       = '0;
        value_override_val      = '0;
        din_enable_override_en  = '0;
        din_enable_override_val = '1;

        // Port A never takes over pull-up, direction or value.
        din_enable_override_en[PA_BASE +: PA_W] = pa_pinchg_on;
        din_enable_override_en[PA_BASE + PA_ANA7] = pa_pinchg_on[PA_ANA7]
                                                   | analog7_din_disable;
        din_enable_override_en[PA_BASE + PA_ANA6] = pa_pinchg_on[PA_ANA6]
                                                   | analog6_din_disable;

        // Every port B pin forces its input on for pin change.
        din_enable_override_en[PB_BASE +: PB_W] = pb_pinchg_on;

        pullup_override_en[PB_BASE + PB_CLKIN]      = internal_osc_selected;
        dir_override_en[PB_BASE + PB_CLKIN]         = internal_osc_selected;
        din_enable_override_en[PB_BASE + PB_CLKIN]  = internal_osc_selected
                                                     | pb_pinchg_on[PB_CLKIN];
        din_enable_override_val[PB_BASE + PB_CLKIN] = internal_osc_selected
                                                     | pb_pinchg_on[PB_CLKIN];

        pullup_override_en[PB_BASE + PB_SCK]  = spi_slave_mode;
        pullup_override_val[PB_BASE + PB_SCK] = portb_out[PB_SCK]
                                               & ~global_pullup_disable;
        dir_override_en[PB_BASE + PB_SCK]     = spi_slave_mode;
        value_override_en[PB_BASE + PB_SCK]   = spi_master_mode;
        value_override_val[PB_BASE + PB_SCK]  = spi_sck_out;

        pullup_override_en[PB_BASE + PB_MISO]  = spi_master_mode;
        pullup_override_val[PB_BASE + PB_MISO] = portb_out[PB_MISO]
                                                & ~global_pullup_disable;
        dir_override_en[PB_BASE + PB_MISO]     = spi_master_mode;
        value_override_en[PB_BASE + PB_MISO]   = spi_slave_mode;
        value_override_val[PB_BASE + PB_MISO]  = spi_slave_out;

        pullup_override_en[PB_BASE + PB_MOSI]  = spi_slave_mode;
        pullup_override_val[PB_BASE + PB_MOSI] = portb_out[PB_MOSI]
                                                & ~global_pullup_disable;
        dir_override_en[PB_BASE + PB_MOSI]     = spi_slave_mode;
        value_override_en[PB_BASE + PB_MOSI]   = spi_master_mode;
        value_override_val[PB_BASE + PB_MOSI]  = spi_master_out;

        pullup_override_en[PB_BASE + PB_SSEL]  = spi_slave_mode;
        pullup_override_val[PB_BASE + PB_SSEL] = portb_out[PB_SSEL]
                                                & ~global_pullup_disable;
        dir_override_en[PB_BASE + PB_SSEL]     = spi_slave_mode;
        // Outside SPI slave mode direction comes from the port register, so the compare only leaves the
        // chip when software has made the pin an output.
        value_override_en[PB_BASE + PB_SSEL]   = timer1_cmp_b_en;
        value_override_val[PB_BASE + PB_SSEL]  = timer1_cmp_b_out;

        value_override_en[PB_BASE + PB_CMPA]   = timer1_cmp_a_en;
        value_override_val[PB_BASE + PB_CMPA]  = timer1_cmp_a_out;

        // Without the clock-out option bit 0 keeps plain port behaviour.
        if (clock_out_option) begin
            dir_override_en[PB_BASE + PB_CAPT]    = 1'b1;
            dir_override_val[PB_BASE + PB_CAPT]   = 1'b1;
            value_override_en[PB_BASE + PB_CAPT]  = 1'b1;
            value_override_val[PB_BASE + PB_CAPT] = divided_clock_out;
        end
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        pmx_pin_ctrl u_pin (
            .dir_bit                 (pin_dir[i]),
            .out_bit                 (pin_out[i]),
            .global_pullup_disable   (global_pullup_disable),
            .cpu_sleep               (cpu_sleep),
            .pullup_override_en      (pullup_override_en[i]),
            .pullup_override_val     (pullup_override_val[i]),
            .dir_override_en         (dir_override_en[i]),
            .dir_override_val        (dir_override_val[i]),
            .value_override_en       (value_override_en[i]),
            .value_override_val      (value_override_val[i]),
            .din_enable_override_en  (din_enable_override_en[i]),
            .din_enable_override_val (din_enable_override_val[i]),
            .pad_in                  (pad_in[i]),
            .pad_out                 (pad_out[i]),
            .pad_oe_n                (pad_oe_n[i]),
            .pullup_en               (pullup_en[i]),
            .pin_digital_in          (pin_digital_in[i])
        );
    end

    assign porta_pad_out   = pad_out[PA_BASE +: PA_W];
    assign porta_pad_oe_n  = pad_oe_n[PA_BASE +: PA_W];
    assign porta_pullup_en = pullup_en[PA_BASE +: PA_W];
    assign portb_pad_out   = pad_out[PB_BASE +: PB_W];
    assign portb_pad_oe_n  = pad_oe_n[PB_BASE +: PB_W];
    assign portb_pullup_en = pullup_en[PB_BASE +: PB_W];

    // Two-stage synchroniser; only the second stage is looked at.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync_meta <= '0;
            sync_pin  <= '0;
        end else begin
            sync_meta <= pin_digital_in;
            sync_pin  <= sync_meta;
        end
    end

    assign pinchg_src_a = sync_pin[PA_BASE +: PA_W];
    assign pinchg_src_b = sync_pin[PB_BASE +: PB_W];

    // The analog path is the raw pad level, untouched by the input-enable clamp.
    assign analog_ch7_in = porta_pad_in[PA_ANA7];
    assign analog_ch6_in = porta_pad_in[PA_ANA6];

    // Peripherals sample these unsynchronised and resynchronise on their own.
    assign spi_sck_in         = pin_digital_in[PB_BASE + PB_SCK];
    assign spi_master_in      = pin_digital_in[PB_BASE + PB_MISO];
    assign spi_slave_in       = pin_digital_in[PB_BASE + PB_MOSI];
    assign spi_slave_select_n = pin_digital_in[PB_BASE + PB_SSEL];
    assign spi_slave_active   = spi_slave_mode & ~spi_slave_select_n;
    assign timer1_capture_in  = pin_digital_in[PB_BASE + PB_CAPT];
    assign ext_clock_in       = pb6_clock_pin & portb_pad_in[PB_CLKIN];

    assign pb_mask = {~pb7_clock_pin, ~pb6_clock_pin, {(PB_W-2){1'b1}}};

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            porta_in_rd <= PA_RST;
        end else begin
            porta_in_rd <= sync_pin[PA_BASE +: PA_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            portb_dir_rd <= PB_RST;
            portb_out_rd <= PB_RST;
            portb_in_rd  <= PB_RST;
        end else begin
            portb_dir_rd <= portb_dir & pb_mask;
            portb_out_rd <= portb_out & pb_mask;
            portb_in_rd  <= sync_pin[PB_BASE +: PB_W] & pb_mask;
        end
    end

endmodule : pmx_port_mux

/* File: pmx_port_mux_assertions.sv */
// Concurrent checks on the ports of the port A and port B override multiplexer.
`timescale 1ns/10ps
module pmx_port_mux_assertions
    import pmx_pkg::*;
(
    // Clock, reset and controls
    input wire logic            ref_clk,
    input wire logic            nrst,
    input wire logic [PA_W-1:0] porta_dir,
    input wire logic [PA_W-1:0] porta_out,
    input wire logic            global_pullup_disable,
    input wire logic            cpu_sleep,
    input wire logic            serial_periph_en,
    input wire logic            serial_master_sel,
    input wire logic [1:0]      clock_source_select,
    input wire logic            pb7_clock_use,
    input wire logic            clock_out_option,
    input wire logic            divided_clock_out,
    // Pads
    input wire logic [PA_W-1:0] porta_pad_in,
    input wire logic [PB_W-1:0] portb_pad_in,
    input wire logic [PA_W-1:0] porta_pad_oe_n,
    input wire logic [PA_W-1:0] porta_pullup_en,
    input wire logic [PB_W-1:0] portb_pad_out,
    input wire logic [PB_W-1:0] portb_pad_oe_n,
    input wire logic [PB_W-1:0] portb_pullup_en,
    // Function inputs and read-back
    input wire logic [PB_W-1:0] pinchg_src_b,
    input wire logic            analog_ch7_in,
    input wire logic            analog_ch6_in,
    input wire logic            spi_slave_select_n,
    input wire logic            spi_slave_active,
    input wire logic [PB_W-1:0] portb_dir_rd,
    input wire logic [PB_W-1:0] portb_out_rd,
    input wire logic [PB_W-1:0] portb_in_rd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    pa_dir_a: assert property (porta_pad_oe_n == ~porta_dir)
        else $error("port A direction overridden");
    pa_pullup_a: assert property (porta_pullup_en == (~porta_dir & porta_out
        & {PA_W{!global_pullup_disable}})) else $error("port A pull-up wrong");
    analog_path_a: assert property ({analog_ch7_in, analog_ch6_in} == porta_pad_in[1:0])
        else $error("analog path wrong");
    slave_input_a: assert property (serial_periph_en && !serial_master_sel
        |-> &{portb_pad_oe_n[5], portb_pad_oe_n[3:2]}) else $error("slave pins not input");
    master_input_a: assert property (serial_periph_en && serial_master_sel
        |-> portb_pad_oe_n[4]) else $error("master input pin driven");
    clock_out_a: assert property (clock_out_option |-> !portb_pad_oe_n[0]
        && portb_pad_out[0] == divided_clock_out) else $error("clock output missing");
    slave_active_a: assert property (spi_slave_active == (serial_periph_en
        && !serial_master_sel && !spi_slave_select_n)) else $error("slave activity wrong");
    pinchg_sync_a: assert property ($past(nrst) && $past(nrst, 2) && $past(cpu_sleep, 2) == 1'b0
        |-> (pinchg_src_b & 8'h3f) == ($past(portb_pad_in, 2) & 8'h3f))
        else $error("pin-change source wrong");
    pb7_read_a: assert property (pb7_clock_use [*4]
        |-> {portb_dir_rd[7], portb_out_rd[7], portb_in_rd[7]} == 3'h0)
        else $error("clock pin 7 read not zero");
    pb6_read_a: assert property ((clock_source_select == CLKSRC_EXTERNAL) [*4]
        |-> {portb_dir_rd[6], portb_out_rd[6], portb_in_rd[6]} == 3'h0)
        else $error("clock pin 6 read not zero");
    osc_pin_a: assert property (clock_source_select[1]
        |-> portb_pad_oe_n[6] && !portb_pullup_en[6]) else $error("oscillator pin not released");
endmodule : pmx_port_mux_assertions

bind pmx_port_mux pmx_port_mux_assertions u_chk (.*);

/* File: pmx_periph_model.sv */
// Behavioural model of the peripherals and the external bus master.
`timescale 1ns/10ps
module pmx_periph_model (
    // Clock and select request
    input  wire logic ref_clk,
    input  wire logic sel_req,
    // Peripheral outputs
    output logic      spi_sck_out,
    output logic      spi_master_out,
    output logic      spi_slave_out,
    output logic      divided_clock_out,
    // Slave-select line of the external master
    output logic      sel_n
);
    logic [2:0] cnt = 3'h0;

    // The prescaler runs free through reset; its count steps every cycle so stale values show.
    always @(posedge ref_clk) begin
        cnt <= cnt + 3'h1;
    end
    assign divided_clock_out = cnt[0];
    assign {spi_slave_out, spi_master_out, spi_sck_out} = cnt;
    assign sel_n = !sel_req;
endmodule : pmx_periph_model

/* File: port_a_b_alt_function_mux_tb_top.sv */
// Self-checking testbench of the port A and port B override multiplexer.
`timescale 1ns/10ps
module port_a_b_alt_function_mux_tb_top;
    import pmx_pkg::*;
    logic       ref_clk, nrst, global_pullup_disable, cpu_sleep, pinchg_group_a_en;
    logic       pinchg_group_b_en, analog7_din_disable, analog6_din_disable, sel_req;
    logic       serial_periph_en, serial_master_sel, timer1_cmp_a_en, timer1_cmp_a_out;
    logic       timer1_cmp_b_en, timer1_cmp_b_out, pb7_clock_use, clock_out_option;
    logic       spi_sck_out, spi_master_out, spi_slave_out, divided_clock_out, sel_n;
    logic       analog_ch7_in, analog_ch6_in, spi_sck_in, spi_master_in, spi_slave_in;
    logic       spi_slave_select_n, spi_slave_active, timer1_capture_in, ext_clock_in;
    logic       internal_osc_selected;
    logic [1:0] clock_source_select;
    logic [3:0] porta_dir, porta_out, pinchg_mask_a, porta_pad_in, porta_pad_out, e;
    logic [3:0] porta_pad_oe_n, porta_pullup_en, pinchg_src_a, porta_in_rd;
    logic [7:0] portb_dir, portb_out, pinchg_mask_b, pb_pad, portb_pad_in, portb_pad_out;
    logic [7:0] portb_pad_oe_n, portb_pullup_en, pinchg_src_b, portb_dir_rd, portb_out_rd;
    logic [7:0] portb_in_rd;
    int         miscompares, tests_run, m;

    assign portb_pad_in = {pb_pad[7:3], sel_n, pb_pad[1:0]};
    pmx_port_mux uut (.*);
    pmx_periph_model u_peer (.*);

    always #20 ref_clk = !ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Arguments are taken at the call, so callers let inputs settle 1 ns before it.
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #40000;
        miscompares++;
        test_done();
    end

    initial begin
        ref_clk = 1'b0;
        {nrst, global_pullup_disable, cpu_sleep, pinchg_group_a_en, pinchg_group_b_en} = '0;
        {analog7_din_disable, analog6_din_disable, sel_req, serial_periph_en} = '0;
        {serial_master_sel, timer1_cmp_a_en, timer1_cmp_a_out, timer1_cmp_b_en} = '0;
        {timer1_cmp_b_out, pb7_clock_use, porta_dir, porta_out, pinchg_mask_a} = '0;
        {porta_pad_in, portb_dir, portb_out, pinchg_mask_b, pb_pad} = '0;
        {miscompares, tests_run} = '0;
        clock_out_option = 1'b1;
        clock_source_select = CLKSRC_RESERVED;
        for (m = 0; m < 10; m++) begin
            cyc(1);
            chk({7'h0, divided_clock_out}, {6'h0, portb_pad_oe_n[0], portb_pad_out[0]});
            chk(8'h00, portb_in_rd);
        end
        nrst = 1'b1;
        cyc(2);
        chk({7'h0, divided_clock_out}, {6'h0, portb_pad_oe_n[0], portb_pad_out[0]});
        cyc(1);
        clock_out_option = 1'b0;
        porta_dir = 4'h5;
        porta_out = 4'h3;
        porta_pad_in = 4'h2;
        #1;
        chk(8'h0a, porta_pad_oe_n);
        chk(8'h02, porta_pullup_en);
        chk(8'h01, porta_pad_out & ~porta_pad_oe_n);
        chk(8'h02, {analog_ch7_in, analog_ch6_in});
        cyc(1);
        global_pullup_disable = 1'b1;
        #1;
        chk(8'h00, porta_pullup_en);
        cyc(1);
        // Sleep turns plain inputs off; only overridden pins still reach the sources.
        {global_pullup_disable, cpu_sleep, porta_pad_in, pb_pad} = {2'h1, 4'hf, 8'hff};
        {pinchg_group_a_en, pinchg_group_b_en, analog7_din_disable} = 3'h7;
        pinchg_mask_a = 4'h4;
        pinchg_mask_b = 8'h09;
        cyc(4);
        chk(8'h06, pinchg_src_a);
        chk(8'h06, porta_in_rd);
        chk(8'h09, pinchg_src_b);
        cyc(1);
        analog6_din_disable = 1'b1;
        pinchg_group_b_en = 1'b0;
        cyc(4);
        chk(8'h07, porta_in_rd);
        chk(8'h00, pinchg_src_b);
        cyc(1);
        {cpu_sleep, portb_dir, portb_out, pb_pad} = {1'b0, 8'hff, 8'hff, 8'h28};
        for (m = 0; m < 3; m++) begin
            cyc(1);
            serial_periph_en = (m != 0);
            serial_master_sel = (m == 2);
            sel_req = (m == 1);
            e = {m == 1, m == 2, m == 1, m == 1};
            #1;
            chk({4'h0, e}, portb_pad_oe_n[5:2]);
            chk({4'h0, e}, portb_pullup_en[5:2]);
            chk({4'h0, m == 2 ? spi_sck_out : 1'b1, m == 1 ? spi_slave_out : 1'b1,
                 m == 2 ? spi_master_out : 1'b1, 1'b1},
                portb_pad_out[5:2] | portb_pad_oe_n[5:2]);
            chk({5'h0, 3'h5} << 1 | (m != 1),
                {spi_sck_in, spi_master_in, spi_slave_in, spi_slave_select_n});
            chk(m == 1, spi_slave_active);
        end
        cyc(1);
        {serial_master_sel, sel_req} = 2'h0;
        #1;
        chk(8'h00, spi_slave_active);
        cyc(1);
        {serial_periph_en, timer1_cmp_a_en, timer1_cmp_b_en} = 3'h3;
        #1;
        chk(8'h00, portb_pad_out[2:1]);
        cyc(1);
        {timer1_cmp_a_out, timer1_cmp_b_out, portb_out} = {2'h3, 8'h00};
        #1;
        chk(8'h03, portb_pad_out[2:1]);
        cyc(1);
        portb_dir = 8'hf9;
        #1;
        chk(8'h03, portb_pad_oe_n[2:1]);
        cyc(1);
        {portb_dir, portb_out, pb_pad} = {8'h00, 8'h01, 8'h01};
        #1;
        chk(8'h03, {timer1_capture_in, portb_pullup_en[0]});
        chk(8'h01, portb_pad_oe_n[0]);
        cyc(1);
        {portb_dir, portb_out, pb_pad, pb7_clock_use} = {8'hff, 8'hff, 8'hff, 1'b1};
        cyc(4);
        chk(8'h00, {portb_dir_rd[7], portb_out_rd[7], portb_in_rd[7]});
        pb7_clock_use = 1'b0;
        cyc(4);
        chk(8'h07, {portb_dir_rd[7], portb_out_rd[7], portb_in_rd[7]});
        for (m = 0; m < 4; m++) begin
            clock_source_select = m[1:0];
            cyc(4);
            chk({6'h0, m >= 2, m == 0}, {6'h0, internal_osc_selected, ext_clock_in});
            if (m < 2) begin
                chk(m, portb_dir_rd[6]);
            end
        end
        chk(8'h02, {portb_pad_oe_n[6], portb_pullup_en[6]});
        test_done();
    end
endmodule : port_a_b_alt_function_mux_tb_top
